// [core/ccsd_map.svh]
`ifndef CCSD_MAP_SVH
`define CCSD_MAP_SVH

// Register offsets on the plain register port.
`define CCSD_ADDR_PORT2_MODE_REG_ONE      8'hA4
`define CCSD_ADDR_DIV       8'hA5
`define CCSD_ADDR_STAT      8'hA6

// Field positions.
`define CCSD_PORT2_MODE_REG_ONE_CKO_BIT   4
`define CCSD_CFG_MODE_MSB   2
`define CCSD_CFG_MODE_LSB   0
`define CCSD_CFG_COMPAT_BIT 7
`define CCSD_STAT_RUN_BIT   7
`define CCSD_STAT_CMP_BIT   6
`define CCSD_STAT_CKO_BIT   5

// Reset values.
`define CCSD_PORT2_MODE_REG_ONE_RESET     8'h00
`define CCSD_DIV_RESET      8'h00

// Oscillator restart waits, in CPU clocks.
`define CCSD_START_XTAL     11'h400
`define CCSD_START_RC       11'h100

// Counter end values and ratio terms.
`define CCSD_MCYC_LAST      3'h5
`define CCSD_CKO_LAST       2'h2
`define CCSD_RATIO_ONE      11'h001
`define CCSD_RATIO_TWO      11'h002

// Supported oscillator frequency limits, in kHz.
`define CCSD_LOW_MIN_KHZ    20
`define CCSD_MED_MIN_KHZ    100
`define CCSD_HIGH_MIN_KHZ   4000
`define CCSD_HIGH_MAX_KHZ   20000
`define CCSD_RC_TYP_KHZ     6000

`endif

// [core/ccsd_pkg.sv]
package ccsd_pkg;

  // Oscillator source chosen by the configuration byte.
  typedef enum logic [2:0] {
    ccsd_mode_xtal_high = 3'h0,
    ccsd_mode_xtal_med  = 3'h1,
    ccsd_mode_xtal_low  = 3'h2,
    ccsd_mode_rc        = 3'h3,
    ccsd_mode_ext       = 3'h7
  } ccsd_mode_type;

  // Oscillator start-up state.
  typedef enum logic {
    ccsd_st_wait = 1'b0,
    ccsd_st_run  = 1'b1
  } ccsd_run_type;

  // Whole state of the main module.
  typedef struct packed {
    logic          cfg_done;
    ccsd_mode_type mode;
    logic          compat;
    logic [7:0]    port2_mode_reg_one;
    logic [7:0]    div_sw;
    logic [7:0]    div_act;
    logic [9:0]    cnt;
    logic [2:0]    mcyc;
    logic [10:0]   wait_cnt;
    ccsd_run_type  run;
    logic          cpu_tick;
    logic          mcyc_tick;
    logic [7:0]    rdata;
    logic          p0_gpio;
    logic          p1_gpio;
    logic          cko_en;
  } ccsd_top_state_type;

  // Whole state of the clock output generator.
  typedef struct packed {
    logic [1:0] cnt;
    logic       level;
  } ccsd_cko_state_type;

endpackage

// [core/ccsd_cko_if.sv]
`timescale 1ns/1ns
`default_nettype none

// Link between the divider core and the clock output generator.
interface ccsd_cko_if;
  logic cpu_tick;
  logic enable;
  logic level;

  modport gen (input cpu_tick, input enable, output level);
  modport ctl (output cpu_tick, output enable, input level);
endinterface

`default_nettype wire

// [core/ccsd_cko_gen.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ccsd_map.svh"

module ccsd_cko_gen (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Control link.
  ccsd_cko_if.gen   cko
);

  ccsd_pkg::ccsd_cko_state_type st_r;
  ccsd_pkg::ccsd_cko_state_type st_nxt;

  // Toggle every third CPU clock, giving one sixth of the rate.
  always_comb begin
    st_nxt = st_r;
    if (!cko.enable) begin
      st_nxt.cnt   = 2'h0;
      st_nxt.level = 1'b0;
    end else if (cko.cpu_tick) begin
      if (st_r.cnt == `CCSD_CKO_LAST) begin
        st_nxt.cnt   = 2'h0;
        st_nxt.level = ~st_r.level;
      end else begin
        st_nxt.cnt = st_r.cnt + 2'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The pin level comes straight from the flip-flop.
  assign cko.level = st_r.level;

  ////////////////////////////////////////////////////////////////////////////

  a_cko_toggle: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cko.enable && cko.cpu_tick && st_r.cnt == `CCSD_CKO_LAST
    |=> st_r.level != $past(st_r.level))
    else $error("Clock output did not toggle on the third CPU clock.");

  a_cko_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cko.enable && $past(cko.enable) && !$past(cko.cpu_tick)
    |-> $stable(st_r.level))
    else $error("Clock output moved without a CPU clock.");

endmodule

`default_nettype wire

// [core/ccsd_top.sv]
// Behaviour
// - Crystal options low, medium, high speed are fixed in config.
// - On-chip RC source runs nominally 6 MHz, reducible by the divider.
// - External clock mode frees the oscillator output pin as port pin.
// - Clock output exists only with RC or external clock sources.
// - Enabled clock output runs with the oscillator, Idle included.
// - Clock output frequency is one sixth of the CPU clock.
// - Compatibility bit halves the CPU clock: 12 clocks per cycle.
// - Peripheral machine-cycle timing follows the halved CPU clock too.
// - Divider zero, the reset value, leaves the rate undivided.
// - Divider N from 1 to 255 divides by 2 times (N+1).
// - A new divider value may be written anytime without stalling.
// - Clock output enable is bit 4 of port 2 mode register A4h.
// - Crystal options take both oscillator pins away from port use.
// - After restart wait 1024 CPU clocks for crystal, 256 otherwise.
//
// The address map and the strobed register port were chosen for this implementation.
`include "ccsd_map.svh"
`timescale 1ns/1ns
`default_nettype none

module ccsd_top (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Nonvolatile configuration and power control.
  input  wire logic [7:0] user_config_byte_one,
  input  wire logic       osc_restart,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // CPU timing.
  output logic            cpu_clk_en,
  output logic            machine_cycle_en,
  output logic            cpu_run,
  // Oscillator pins.
  output logic            divided_clock_pin,
  output logic            divided_clock_pin_oe,
  output logic            port2_pin0_gpio_en,
  output logic            port2_pin1_gpio_en
);

  ccsd_pkg::ccsd_top_state_type st_r;
  ccsd_pkg::ccsd_top_state_type st_nxt;
  logic [10:0]                  ratio;
  logic [9:0]                   ratio_last;
  logic [10:0]                  start_lim;
  logic                         is_xtal;
  logic                         cko_ok;

  ccsd_cko_if cko_link ();

  ////////////////////////////////////////////////////////////////////////////

  // Division ratio from the active divider and the compatibility bit.
  always_comb begin
    if (st_r.div_act == 8'h00) begin
      ratio = `CCSD_RATIO_ONE;
    end else begin
      ratio = {2'h0, st_r.div_act, 1'b0} + `CCSD_RATIO_TWO;
    end
    if (st_r.compat) begin
      ratio = {ratio[9:0], 1'b0};
    end
  end

  // Last count of one divided period and the restart wait for the source.
  assign ratio_last = 10'(ratio - `CCSD_RATIO_ONE);
  assign is_xtal    = st_r.mode == ccsd_pkg::ccsd_mode_xtal_high
                   || st_r.mode == ccsd_pkg::ccsd_mode_xtal_med
                   || st_r.mode == ccsd_pkg::ccsd_mode_xtal_low;
  assign start_lim  = is_xtal ? `CCSD_START_XTAL : `CCSD_START_RC;
  assign cko_ok     = st_r.mode == ccsd_pkg::ccsd_mode_rc
                   || st_r.mode == ccsd_pkg::ccsd_mode_ext;

  ////////////////////////////////////////////////////////////////////////////

  // Next state of the whole block.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.cpu_tick  = 1'b0;
    st_nxt.mcyc_tick = 1'b0;
    st_nxt.rdata     = 8'h00;

    // The configuration byte is caught once, on the first edge after reset.
    if (!st_r.cfg_done) begin
      st_nxt.cfg_done = 1'b1;
      st_nxt.compat   = user_config_byte_one[`CCSD_CFG_COMPAT_BIT];
      unique case (user_config_byte_one[`CCSD_CFG_MODE_MSB:`CCSD_CFG_MODE_LSB])
        3'h0:    st_nxt.mode = ccsd_pkg::ccsd_mode_xtal_high;
        3'h1:    st_nxt.mode = ccsd_pkg::ccsd_mode_xtal_med;
        3'h2:    st_nxt.mode = ccsd_pkg::ccsd_mode_xtal_low;
        3'h7:    st_nxt.mode = ccsd_pkg::ccsd_mode_ext;
        default: st_nxt.mode = ccsd_pkg::ccsd_mode_rc;
      endcase
    end else begin
      // Divided CPU clock; the divider only changes at a period end.
      if (st_r.cnt >= ratio_last) begin
        st_nxt.cnt      = 10'h000;
        st_nxt.cpu_tick = 1'b1;
        st_nxt.div_act  = st_r.div_sw;
      end else begin
        st_nxt.cnt = st_r.cnt + 10'h001;
      end

      // Machine cycle of six CPU clocks drives peripheral timing.
      if (st_nxt.cpu_tick) begin
        if (st_r.mcyc == `CCSD_MCYC_LAST) begin
          st_nxt.mcyc      = 3'h0;
          st_nxt.mcyc_tick = 1'b1;
        end else begin
          st_nxt.mcyc = st_r.mcyc + 3'h1;
        end
      end

      // Start-up wait counted in CPU clocks after each restart.
      if (osc_restart) begin
        st_nxt.run      = ccsd_pkg::ccsd_st_wait;
        st_nxt.wait_cnt = 11'h000;
      end else begin
        unique case (st_r.run)
          ccsd_pkg::ccsd_st_wait: begin
            if (st_nxt.cpu_tick) begin
              if (st_r.wait_cnt == 11'(start_lim - `CCSD_RATIO_ONE)) begin
                st_nxt.run = ccsd_pkg::ccsd_st_run;
              end else begin
                st_nxt.wait_cnt = st_r.wait_cnt + 11'h001;
              end
            end
          end
          ccsd_pkg::ccsd_st_run: begin
            st_nxt.wait_cnt = 11'h000;
          end
        endcase
      end
    end

    // Pin ownership and clock output enable follow the source.
    st_nxt.cko_en  = cko_ok && st_r.port2_mode_reg_one[`CCSD_PORT2_MODE_REG_ONE_CKO_BIT];
    st_nxt.p1_gpio = st_r.mode == ccsd_pkg::ccsd_mode_rc;
    st_nxt.p0_gpio = cko_ok && !st_r.port2_mode_reg_one[`CCSD_PORT2_MODE_REG_ONE_CKO_BIT];

    // Register writes; the divider may change at any time.
    if (reg_wr) begin
      if (reg_addr == `CCSD_ADDR_PORT2_MODE_REG_ONE) begin
        st_nxt.port2_mode_reg_one = reg_wdata;
      end
      if (reg_addr == `CCSD_ADDR_DIV) begin
        st_nxt.div_sw = reg_wdata;
      end
    end

    // Register reads answer on the next cycle; unmapped reads give zero.
    if (reg_rd) begin
      if (reg_addr == `CCSD_ADDR_PORT2_MODE_REG_ONE) begin
        st_nxt.rdata = st_r.port2_mode_reg_one;
      end else if (reg_addr == `CCSD_ADDR_DIV) begin
        st_nxt.rdata = st_r.div_sw;
      end else if (reg_addr == `CCSD_ADDR_STAT) begin
        st_nxt.rdata = {st_r.run == ccsd_pkg::ccsd_st_run, st_r.compat,
                        st_r.cko_en, 2'h0, st_r.mode};
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r         <= '0;
      st_r.port2_mode_reg_one    <= `CCSD_PORT2_MODE_REG_ONE_RESET;
      st_r.div_sw  <= `CCSD_DIV_RESET;
      st_r.div_act <= `CCSD_DIV_RESET;
      st_r.mode    <= ccsd_pkg::ccsd_mode_rc;
      st_r.run     <= ccsd_pkg::ccsd_st_wait;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Clock output generator; it ignores Idle and runs with the oscillator.
  assign cko_link.cpu_tick = st_r.cpu_tick;
  assign cko_link.enable   = st_r.cko_en;

  ccsd_cko_gen u_cko (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .cko     (cko_link.gen)
  );

  // Outputs come straight from flip-flops.
  assign reg_rdata            = st_r.rdata;
  assign cpu_clk_en           = st_r.cpu_tick;
  assign machine_cycle_en     = st_r.mcyc_tick;
  assign cpu_run              = st_r.run == ccsd_pkg::ccsd_st_run;
  assign divided_clock_pin    = cko_link.level;
  assign divided_clock_pin_oe = st_r.cko_en;
  assign port2_pin0_gpio_en   = st_r.p0_gpio;
  assign port2_pin1_gpio_en   = st_r.p1_gpio;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_cko_source_gate: assert property (
    divided_clock_pin_oe |-> cko_ok)
    else $error("Clock output driven with a crystal source.");

  a_xtal_pins_off: assert property (
    st_r.cfg_done && is_xtal |=> !port2_pin0_gpio_en && !port2_pin1_gpio_en)
    else $error("Oscillator pin offered as port pin in crystal mode.");

  a_ext_pin_free: assert property (
    st_r.cfg_done && st_r.mode == ccsd_pkg::ccsd_mode_ext
    && !st_r.port2_mode_reg_one[`CCSD_PORT2_MODE_REG_ONE_CKO_BIT] |=> port2_pin0_gpio_en)
    else $error("Output pin not released in external clock mode.");

  a_div_zero_rate: assert property (
    cpu_clk_en && !st_r.compat && st_r.div_act == 8'h00
    && st_r.div_sw == 8'h00 |=> cpu_clk_en)
    else $error("Undivided CPU clock skipped a cycle.");

  a_compat_half: assert property (
    cpu_clk_en && st_r.compat && st_r.div_act == 8'h00
    && st_r.div_sw == 8'h00 |=> !cpu_clk_en ##1 cpu_clk_en)
    else $error("Compatibility mode did not halve the CPU clock.");

  a_div_ratio_four: assert property (
    cpu_clk_en && !st_r.compat && st_r.div_act == 8'h01
    && st_r.div_sw == 8'h01 |=> !cpu_clk_en [*3] ##1 cpu_clk_en)
    else $error("Divider value one did not divide by four.");

  a_div_boundary: assert property (
    $changed(st_r.div_act) |-> cpu_clk_en)
    else $error("Divider changed inside a divided period.");

  a_mcyc_on_tick: assert property (
    machine_cycle_en |-> cpu_clk_en && st_r.mcyc == 3'h0)
    else $error("Machine cycle pulse not aligned to a CPU clock.");

  a_start_wait: assert property (
    $rose(cpu_run)
    |-> $past(st_r.wait_cnt) == 11'(start_lim - `CCSD_RATIO_ONE))
    else $error("Start-up wait ended at the wrong CPU clock count.");

  ////////////////////////////////////////////////////////////////////////////

  // Pins, clock output, divider ratio, register writes and reads, start-up control and the fixed configuration.
  a_cfg_fixed: assert property (
    st_r.cfg_done |=> $stable(st_r.mode) && $stable(st_r.compat))
    else $error("Oscillator configuration changed after capture.");

  a_rc_pin1_free: assert property (
    st_r.cfg_done && st_r.mode == ccsd_pkg::ccsd_mode_rc
    |=> port2_pin1_gpio_en)
    else $error("Input pin not offered as port pin with the RC source.");

  a_ext_pin1_taken: assert property (
    st_r.cfg_done && st_r.mode == ccsd_pkg::ccsd_mode_ext
    |=> !port2_pin1_gpio_en)
    else $error("Input pin offered as port pin with an external clock.");

  a_cko_enable_on: assert property (
    st_r.cfg_done && cko_ok && st_r.port2_mode_reg_one[`CCSD_PORT2_MODE_REG_ONE_CKO_BIT]
    |=> divided_clock_pin_oe)
    else $error("Clock output enable lost while the oscillator runs.");

  a_cko_off_low: assert property (
    !divided_clock_pin_oe |=> !divided_clock_pin)
    else $error("Clock output level high while not driven.");

  a_div_ratio_six: assert property (
    cpu_clk_en && !st_r.compat && st_r.div_act == 8'h02
    |=> !cpu_clk_en [*5] ##1 cpu_clk_en)
    else $error("Divider value two did not divide by six.");

  a_div_write: assert property (
    reg_wr && reg_addr == `CCSD_ADDR_DIV
    |=> st_r.div_sw == $past(reg_wdata))
    else $error("Divider write did not land.");

  a_run_keeps: assert property (
    cpu_run && !osc_restart |=> cpu_run)
    else $error("CPU stopped without an oscillator restart.");

  a_mode_write: assert property (
    reg_wr && reg_addr == `CCSD_ADDR_PORT2_MODE_REG_ONE
    |=> st_r.port2_mode_reg_one == $past(reg_wdata))
    else $error("Port mode write did not land.");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data shown without a read strobe.");

  a_stat_compat: assert property (
    reg_rd && reg_addr == `CCSD_ADDR_STAT
    |=> reg_rdata[`CCSD_STAT_CMP_BIT] == st_r.compat)
    else $error("Status read shows the wrong compatibility bit.");

  a_restart_halt: assert property (
    st_r.cfg_done && osc_restart |=> !cpu_run)
    else $error("Oscillator restart did not hold the CPU.");

endmodule

`default_nettype wire

// [bench/ccsd_osc_src.sv]
`timescale 1ns/1ns
`default_nettype none

// Stand-in for the outside clock source on the oscillator input pin.
module ccsd_osc_src #(
  parameter int HALF_NS = 50
) (
  // Oscillator output.
  output logic clk_sys
);
  // Free-running source, well inside the supported external rate.
  initial begin
    clk_sys = 1'h0;
    forever #HALF_NS clk_sys = ~clk_sys;
  end
endmodule

`default_nettype wire

// [bench/ccsd_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module ccsd_top_tb;
  // Design connections and bench state.
  logic       clk_sys;
  logic       rstn;
  logic [7:0] cfg;
  logic       osc_restart;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       cpu_clk_en;
  logic       mc_en;
  logic       cpu_run;
  logic       cko;
  logic       cko_oe;
  logic       p0_en;
  logic       p1_en;
  int         err_count;
  int         checked;
  int         n;
  int         r;
  logic       rc;
  logic [7:0] d;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};

  ccsd_osc_src i_osc (.clk_sys(clk_sys));

  ccsd_top i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .user_config_byte_one(cfg),
    .osc_restart(osc_restart), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en),
    .machine_cycle_en(mc_en), .cpu_run(cpu_run),
    .divided_clock_pin(cko), .divided_clock_pin_oe(cko_oe),
    .port2_pin0_gpio_en(p0_en), .port2_pin1_gpio_en(p1_en)
  );

  //////////////////////////////////////////////////////////////////////
  // Comparisons and the closing report.
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Register port cycles; read data stand in the cycle after the strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask

  // Reset with a given configuration byte, held for 20 cycles.
  task automatic do_reset(input logic [7:0] c);
    rstn <= 1'h0;
    cfg  <= c;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
  endtask

  // Counts cycles until the start-up wait is over.
  task automatic wait_run(input int lo, input int hi);
    int c;
    c = 0;
    while (cpu_run !== 1'h1 && c < 3000) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk_n("start_wait_in_range", 1, int'(c >= lo && c <= hi));
  endtask

  // Picks the output whose period is measured.
  function automatic logic pick(input int s);
    case (s)
      0: return cpu_clk_en;
      1: return mc_en;
      default: return cko;
    endcase
  endfunction

  // Cycles between two pulses, or two rising edges of the clock output.
  task automatic meas(input int s, output int p);
    logic v;
    logic q;
    int   i;
    p = 0;
    q = 1'h1;
    v = 1'h0;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk_sys);
      #1;
      v = pick(s);
      if (v === 1'h1 && (s != 2 || q === 1'h0)) break;
      q = v;
    end
    q = v;
    for (i = 1; i < 4000; i++) begin
      @(posedge clk_sys);
      #1;
      v = pick(s);
      if (v === 1'h1 && (s != 2 || q === 1'h0)) begin
        p = i;
        break;
      end
      q = v;
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    err_count = 0;
    checked = 0;
    rstn = 1'h0;
    cfg = 8'h00;
    osc_restart = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    // Every oscillator source, its start-up wait, pins and clock output.
    foreach (modes[i]) begin
      rc = (modes[i] == 3'h3 || modes[i] == 3'h7);
      do_reset({5'h00, modes[i]});
      wait_run(rc ? 256 : 1024, rc ? 262 : 1030);
      rd(8'hA6, d);
      chk8("status", {3'h4, 2'h0, modes[i]}, d);
      chk8("pin0_free", {7'h00, rc}, {7'h00, p0_en});
      chk8("pin1_free", {7'h00, modes[i] == 3'h3},
           {7'h00, p1_en});
      wr(8'hA4, 8'h10);
      @(posedge clk_sys);
      #1;
      chk8("cko_oe", {7'h00, rc}, {7'h00, cko_oe});
      chk8("pin0_taken", 8'h00, {7'h00, p0_en});
      if (rc) begin
        meas(2, n);
        chk_n("cko_period", 6, n);
      end
    end
    // RC source from a spare source code: registers and read-only status.
    do_reset(8'h05);
    wait_run(256, 262);
    rd(8'hA4, d);
    chk8("mode_reg_reset", 8'h00, d);
    rd(8'hA5, d);
    chk8("div_reset", 8'h00, d);
    wr(8'hA4, 8'hFF);
    rd(8'hA4, d);
    chk8("mode_reg", 8'hFF, d);
    @(posedge clk_sys);
    #1;
    chk8("rdata_idle", 8'h00, reg_rdata);
    wr(8'hA7, 8'h55);
    rd(8'hA7, d);
    chk8("unmapped", 8'h00, d);
    wr(8'hA6, 8'h00);
    rd(8'hA6, d);
    chk8("status_ro", 8'hA3, d);
    // Divider ratios and machine cycle spacing.
    foreach (divs[i]) begin
      r = (divs[i] == 8'h00) ? 1 : 2 * (int'(divs[i]) + 1);
      wr(8'hA5, divs[i]);
      rd(8'hA5, d);
      chk8("div_readback", divs[i], d);
      meas(0, n);
      meas(0, n);
      chk_n("cpu_ratio", r, n);
      meas(1, n);
      chk_n("mcyc_period", 6 * r, n);
      if (divs[i] == 8'h01) begin
        meas(2, n);
        chk_n("cko_div_period", 6 * r, n);
      end
    end
    // A machine cycle pulse just ended a 512 period; change mid-period.
    wr(8'hA5, 8'h01);
    n = 0;
    while (cpu_clk_en !== 1'h1 && n < 600) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk_n("old_period_kept", 510, n);
    meas(0, n);
    chk_n("new_ratio", 4, n);
    chk8("still_running", 8'h01, {7'h00, cpu_run});
    // Oscillator restart with a ratio of four.
    @(posedge clk_sys);
    osc_restart <= 1'h1;
    @(posedge clk_sys);
    osc_restart <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk8("restart_halts", 8'h00, {7'h00, cpu_run});
    wait_run(1020, 1045);
    // Half-speed compatibility.
    do_reset(8'h83);
    wait_run(512, 530);
    rd(8'hA6, d);
    chk8("compat_status", 8'hC3, d);
    meas(0, n);
    chk_n("compat_ratio", 2, n);
    meas(1, n);
    chk_n("compat_mcyc", 12, n);
    wr(8'hA4, 8'h10);
    meas(2, n);
    meas(2, n);
    chk_n("compat_cko", 12, n);
    // Software turns the clock output off, as before entering Idle.
    wr(8'hA4, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk8("cko_off_oe", 8'h00, {7'h00, cko_oe});
    chk8("cko_off_level", 8'h00, {7'h00, cko});
    wr(8'hA5, 8'h01);
    meas(0, n);
    meas(0, n);
    chk_n("compat_div", 8, n);
    finish_test;
  end

  // Watchdog against a hang.
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    finish_test;
  end
endmodule

`default_nettype wire
